// ===== qtim_pkg.sv
package qtim_pkg;
    // counter geometry
    localparam int          QTIM_CNT_W   = 16;
    localparam logic [15:0] QTIM_CNT_MAX = 16'hffff;
    localparam logic [15:0] QTIM_CNT_ONE = 16'h0001;
    localparam logic [15:0] QTIM_CNT_ZERO = 16'h0000;
    localparam int          QTIM_NUM_TIMERS = 4;
    localparam int          QTIM_BIG_CH  = 3;
    localparam int          QTIM_SMALL_CH = 2;

    // counting modes
    typedef enum logic [1:0] {QTIM_STOP, QTIM_UP, QTIM_CONT, QTIM_UPDOWN} qtim_mode_t;

    // counting clock select
    typedef enum logic [1:0] {QTIM_CLK_EXT, QTIM_CLK_AUX, QTIM_CLK_SUBMAIN, QTIM_CLK_OFF} qtim_clksel_t;

    // capture input select
    typedef enum logic [1:0] {QTIM_IN_PRI, QTIM_IN_ALT, QTIM_IN_GND, QTIM_IN_VCC} qtim_insel_t;

    // capture edge select
    typedef enum logic [1:0] {QTIM_EDGE_NONE, QTIM_EDGE_RISE, QTIM_EDGE_FALL, QTIM_EDGE_BOTH} qtim_edge_t;

    // channel output modes
    typedef enum logic [1:0] {QTIM_OUT_BIT, QTIM_OUT_SET, QTIM_OUT_TOGGLE, QTIM_OUT_RSTSET} qtim_outmode_t;

    // infrared modulation mode select values
    localparam logic QTIM_IR_ASK = 1'b0;
    localparam logic QTIM_IR_FSK = 1'b1;
    // infrared data source select values
    localparam logic QTIM_IR_SRC_SERIAL = 1'b0;
    localparam logic QTIM_IR_SRC_BIT    = 1'b1;
endpackage : qtim_pkg

// ===== qtim_top.sv
`timescale 1ns/1ps
// How it works
// - big timers: 16-bit counter, three channels, each repeated capture or compare.
// - big timers also give PWM outputs and interval timing.
// - big timers pulse an event on overflow and on each channel event.
// - channel zero has no pin; only period timing and events.
// - in up mode channel zero value sets the wrap count.
// - small timers: 16-bit counter, two channels, compare, interval timing; only timer 3 captures, from timer 2 outputs.
// - small timers pulse an event on overflow and per channel event.
// - small timers reach no pin; no PWM output.
// - big timer outputs modulate the serial transmit pin, ASK or FSK.
// - enable, polarity, mode, data source and data bit steer modulation.
// - real-time counter overflow feeds timer zero channel one alternate input.

////////////////////////////////////////////////////////////////////////////////
module qtim_timer
    import qtim_pkg::*;
#(
    parameter int NCH = 3
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       nrst,
    // counting
    input  wire logic                       tick,
    input  wire logic [1:0]                 mode,
    // channel value write
    input  wire logic                       ccrWrEn,
    input  wire logic [1:0]                 ccrWrChan,
    input  wire logic [QTIM_CNT_W-1:0]      ccrWrData,
    // channel configuration
    input  wire logic [NCH-1:0]             capMode,
    input  wire logic [NCH-1:0][1:0]        capEdge,
    input  wire logic [NCH-1:0][1:0]        inSel,
    input  wire logic [NCH-1:0][1:0]        outMode,
    input  wire logic [NCH-1:0]             outValue,
    // capture inputs
    input  wire logic [NCH-1:0]             capInA,
    input  wire logic [NCH-1:0]             capInB,
    // state and events
    output logic      [QTIM_CNT_W-1:0]      count,
    output logic      [NCH-1:0][QTIM_CNT_W-1:0] ccrVal,
    output logic      [NCH-1:0]             chanOut,
    output logic                            ovfEvent,
    output logic      [NCH-1:0]             chanEvent
);
    function automatic logic pickInput(input logic [1:0] sel, input logic a, input logic b);
        unique case (qtim_insel_t'(sel))
            QTIM_IN_PRI: pickInput = a;
            QTIM_IN_ALT: pickInput = b;
            QTIM_IN_GND: pickInput = 1'b0;
            QTIM_IN_VCC: pickInput = 1'b1;
        endcase
    endfunction : pickInput

    function automatic logic edgeHit(input logic [1:0] sel, input logic prev, input logic cur);
        unique case (qtim_edge_t'(sel))
            QTIM_EDGE_NONE: edgeHit = 1'b0;
            QTIM_EDGE_RISE: edgeHit = ~prev & cur;
            QTIM_EDGE_FALL: edgeHit = prev & ~cur;
            QTIM_EDGE_BOTH: edgeHit = prev ^ cur;
        endcase
    endfunction : edgeHit

    ////////////////////////////////////////////////////////////////////////////
    // counter
    logic [QTIM_CNT_W-1:0] cnt_reg, cnt_next;
    logic                  dir_reg, dir_next;
    logic                  ovf_reg, ovf_next;
    logic [NCH-1:0][QTIM_CNT_W-1:0] ccr_reg, ccr_next;

    always_comb begin
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        ovf_next = 1'b0;
        if (tick) begin
            unique case (qtim_mode_t'(mode))
                QTIM_STOP: begin
                    cnt_next = cnt_reg;
                end
                QTIM_UP: begin
                    if (cnt_reg >= ccr_reg[0]) begin
                        cnt_next = QTIM_CNT_ZERO;
                        ovf_next = 1'b1;
                    end else begin
                        cnt_next = cnt_reg + QTIM_CNT_ONE;
                    end
                end
                QTIM_CONT: begin
                    cnt_next = cnt_reg + QTIM_CNT_ONE;
                    ovf_next = (cnt_reg == QTIM_CNT_MAX);
                end
                QTIM_UPDOWN: begin
                    if (dir_reg) begin
                        if (cnt_reg >= ccr_reg[0]) begin
                            // period value of one steps straight back to zero
                            if (cnt_reg == QTIM_CNT_ONE) begin
                                cnt_next = QTIM_CNT_ZERO;
                                ovf_next = 1'b1;
                            end else if (cnt_reg != QTIM_CNT_ZERO) begin
                                dir_next = 1'b0;
                                cnt_next = cnt_reg - QTIM_CNT_ONE;
                            end
                        end else begin
                            cnt_next = cnt_reg + QTIM_CNT_ONE;
                        end
                    end else if (cnt_reg == QTIM_CNT_ZERO) begin
                        dir_next = 1'b1;
                    end else begin
                        cnt_next = cnt_reg - QTIM_CNT_ONE;
                        if (cnt_reg == QTIM_CNT_ONE) begin
                            dir_next = 1'b1;
                            ovf_next = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_reg <= QTIM_CNT_ZERO;
            dir_reg <= 1'b1;
            ovf_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            dir_reg <= dir_next;
            ovf_reg <= ovf_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // capture / compare channels
    logic [NCH-1:0]                 out_reg, out_next;
    logic [NCH-1:0]                 ev_reg, ev_next;
    logic [NCH-1:0]                 prev_reg, prev_next;
    logic [NCH-1:0]                 selIn;
    logic [NCH-1:0]                 cmpHit;
    logic                           running;

    always_comb begin
        running = tick && (qtim_mode_t'(mode) != QTIM_STOP);
        for (int c = 0; c < NCH; c++) begin
            selIn[c]     = pickInput(inSel[c], capInA[c], capInB[c]);
            cmpHit[c]    = running && (cnt_reg == ccr_reg[c]);
            ccr_next[c]  = ccr_reg[c];
            out_next[c]  = out_reg[c];
            ev_next[c]   = 1'b0;
            prev_next[c] = selIn[c];
            if (capMode[c]) begin
                // capture: latch count on selected edge, repeatable
                if (edgeHit(capEdge[c], prev_reg[c], selIn[c])) begin
                    ccr_next[c] = cnt_reg;
                    ev_next[c]  = 1'b1;
                end
            end else begin
                if (ccrWrEn && (ccrWrChan == 2'(c))) begin
                    ccr_next[c] = ccrWrData;
                end
                ev_next[c] = cmpHit[c];
            end
            unique case (qtim_outmode_t'(outMode[c]))
                QTIM_OUT_BIT: out_next[c] = outValue[c];
                QTIM_OUT_SET: begin
                    if (cmpHit[c] && !capMode[c]) out_next[c] = 1'b1;
                end
                QTIM_OUT_TOGGLE: begin
                    if (cmpHit[c] && !capMode[c]) out_next[c] = ~out_reg[c];
                end
                QTIM_OUT_RSTSET: begin
                    // pwm: low at channel match, high at period match
                    if (cmpHit[c] && !capMode[c]) out_next[c] = 1'b0;
                    if (cmpHit[0]) out_next[c] = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ccr_reg  <= '0;
            out_reg  <= '0;
            ev_reg   <= '0;
            prev_reg <= '0;
        end else begin
            ccr_reg  <= ccr_next;
            out_reg  <= out_next;
            ev_reg   <= ev_next;
            prev_reg <= prev_next;
        end
    end

    assign count     = cnt_reg;
    assign ccrVal    = ccr_reg;
    assign chanOut   = out_reg;
    assign ovfEvent  = ovf_reg;
    assign chanEvent = ev_reg;
endmodule : qtim_timer

////////////////////////////////////////////////////////////////////////////////
module qtim_top
    import qtim_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // clock sources, sampled as levels
    input  wire logic [3:0]            extClk,
    input  wire logic                  auxClk,
    input  wire logic                  subMainClk,
    // per timer control
    input  wire logic [3:0][1:0]       clkSel,
    input  wire logic [3:0][1:0]       timerMode,
    // channel value write
    input  wire logic                  ccrWrEn,
    input  wire logic [1:0]            ccrWrTimer,
    input  wire logic [1:0]            ccrWrChan,
    input  wire logic [15:0]           ccrWrData,
    // channel configuration, unused channel 2 of small timers ignored
    input  wire logic [3:0][2:0]       capMode,
    input  wire logic [3:0][2:0][1:0]  capEdge,
    input  wire logic [3:0][2:0][1:0]  inSel,
    input  wire logic [3:0][2:0][1:0]  outMode,
    input  wire logic [3:0][2:0]       outValue,
    // pins and internal inputs
    input  wire logic [1:0][2:1]       capPin,
    input  wire logic                  rtcOverflow,
    input  wire logic                  serialTxData,
    // infrared control
    input  wire logic                  infraredEnable,
    input  wire logic                  infraredPolaritySelect,
    input  wire logic                  infraredModeSelect,
    input  wire logic                  infraredDataSourceSelect,
    input  wire logic                  infraredDataValue,
    // outputs
    output logic      [1:0][2:1]       pwmPin,
    output logic                       adcTrigger,
    output logic                       serialTransmitPin,
    output logic      [3:0][15:0]      count,
    output logic      [3:0][2:0][15:0] ccrVal,
    output logic      [3:0]            ovfEvent,
    output logic      [3:0][2:0]       chanEvent
);
    ////////////////////////////////////////////////////////////////////////////
    // clock source edges to tick enables
    logic [3:0] extPrev_reg, extPrev_next;
    logic       auxPrev_reg, auxPrev_next, smPrev_reg, smPrev_next;
    logic [3:0] tick;

    always_comb begin
        extPrev_next = extClk;
        auxPrev_next = auxClk;
        smPrev_next  = subMainClk;
        for (int t = 0; t < QTIM_NUM_TIMERS; t++) begin
            unique case (qtim_clksel_t'(clkSel[t]))
                QTIM_CLK_EXT:     tick[t] = extClk[t] & ~extPrev_reg[t];
                QTIM_CLK_AUX:     tick[t] = auxClk & ~auxPrev_reg;
                QTIM_CLK_SUBMAIN: tick[t] = subMainClk & ~smPrev_reg;
                QTIM_CLK_OFF:     tick[t] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            extPrev_reg <= '0;
            auxPrev_reg <= 1'b0;
            smPrev_reg  <= 1'b0;
        end else begin
            extPrev_reg <= extPrev_next;
            auxPrev_reg <= auxPrev_next;
            smPrev_reg  <= smPrev_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // four timers
    logic [2:0] out0, out1;
    logic [1:0] out2, out3;
    logic [2:0] evt0, evt1;
    logic [1:0] evt2, evt3;
    logic [2:0][15:0] val0, val1;
    logic [1:0][15:0] val2, val3;

    qtim_timer #(.NCH(QTIM_BIG_CH)) timer0 (
        .clk(clk), .nrst(nrst), .tick(tick[0]), .mode(timerMode[0]),
        .ccrWrEn(ccrWrEn && ccrWrTimer == 2'h0), .ccrWrChan(ccrWrChan), .ccrWrData(ccrWrData),
        .capMode(capMode[0]), .capEdge(capEdge[0]), .inSel(inSel[0]), .outMode(outMode[0]),
        .outValue(outValue[0]),
        .capInA({capPin[0][2], capPin[0][1], 1'b0}),
        .capInB({1'b0, rtcOverflow, 1'b0}),
        .count(count[0]), .ccrVal(val0), .chanOut(out0), .ovfEvent(ovfEvent[0]), .chanEvent(evt0)
    );

    qtim_timer #(.NCH(QTIM_BIG_CH)) timer1 (
        .clk(clk), .nrst(nrst), .tick(tick[1]), .mode(timerMode[1]),
        .ccrWrEn(ccrWrEn && ccrWrTimer == 2'h1), .ccrWrChan(ccrWrChan), .ccrWrData(ccrWrData),
        .capMode(capMode[1]), .capEdge(capEdge[1]), .inSel(inSel[1]), .outMode(outMode[1]),
        .outValue(outValue[1]),
        .capInA({capPin[1][2], capPin[1][1], 1'b0}),
        .capInB(out0),
        .count(count[1]), .ccrVal(val1), .chanOut(out1), .ovfEvent(ovfEvent[1]), .chanEvent(evt1)
    );

    qtim_timer #(.NCH(QTIM_SMALL_CH)) timer2 (
        .clk(clk), .nrst(nrst), .tick(tick[2]), .mode(timerMode[2]),
        .ccrWrEn(ccrWrEn && ccrWrTimer == 2'h2), .ccrWrChan(ccrWrChan), .ccrWrData(ccrWrData),
        .capMode(capMode[2][1:0]), .capEdge(capEdge[2][1:0]), .inSel(inSel[2][1:0]),
        .outMode(outMode[2][1:0]), .outValue(outValue[2][1:0]),
        .capInA(2'h0), .capInB(2'h0),
        .count(count[2]), .ccrVal(val2), .chanOut(out2), .ovfEvent(ovfEvent[2]), .chanEvent(evt2)
    );

    qtim_timer #(.NCH(QTIM_SMALL_CH)) timer3 (
        .clk(clk), .nrst(nrst), .tick(tick[3]), .mode(timerMode[3]),
        .ccrWrEn(ccrWrEn && ccrWrTimer == 2'h3), .ccrWrChan(ccrWrChan), .ccrWrData(ccrWrData),
        .capMode(capMode[3][1:0]), .capEdge(capEdge[3][1:0]), .inSel(inSel[3][1:0]),
        .outMode(outMode[3][1:0]), .outValue(outValue[3][1:0]),
        .capInA(2'h0), .capInB(out2),
        .count(count[3]), .ccrVal(val3), .chanOut(out3), .ovfEvent(ovfEvent[3]), .chanEvent(evt3)
    );

    assign ccrVal    = {{16'h0000, val3}, {16'h0000, val2}, val1, val0};
    assign chanEvent = {{1'b0, evt3}, {1'b0, evt2}, evt1, evt0};
    // only big timer channels 1 and 2 reach pins; channel 0 never does
    assign pwmPin    = {out1[2:1], out0[2:1]};
    assign adcTrigger = out1[1];

    ////////////////////////////////////////////////////////////////////////////
    // infrared modulation of the serial transmit pin
    logic txPin_reg, txPin_next;
    logic infrared_data_value, irMod;

    always_comb begin
        infrared_data_value = (infraredDataSourceSelect == QTIM_IR_SRC_BIT) ? infraredDataValue : serialTxData;
        infrared_data_value = infrared_data_value ^ infraredPolaritySelect;
        if (infraredModeSelect == QTIM_IR_FSK) begin
            irMod = infrared_data_value ? out0[2] : out1[2];
        end else begin
            irMod = infrared_data_value & out0[2];
        end
        txPin_next = infraredEnable ? irMod : serialTxData;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            txPin_reg <= 1'b1;
        end else begin
            txPin_reg <= txPin_next;
        end
    end

    assign serialTransmitPin = txPin_reg;
endmodule : qtim_top

// ===== qtim_checker_assertions.sv
`timescale 1ns/1ps
module qtim_checker
    import qtim_pkg::*;
(
    // clock and reset
    input wire logic                  clk,
    input wire logic                  nrst,
    // control
    input wire logic [3:0][1:0]       timerMode,
    input wire logic                  ccrWrEn,
    input wire logic [1:0]            ccrWrTimer,
    input wire logic [1:0]            ccrWrChan,
    input wire logic [15:0]           ccrWrData,
    input wire logic [3:0][2:0]       capMode,
    input wire logic                  serialTxData,
    input wire logic                  infraredEnable,
    input wire logic                  infraredPolaritySelect,
    input wire logic                  infraredModeSelect,
    input wire logic                  infraredDataSourceSelect,
    input wire logic                  infraredDataValue,
    // outputs
    input wire logic [1:0][2:1]       pwmPin,
    input wire logic                  serialTransmitPin,
    input wire logic [3:0][15:0]      count,
    input wire logic [3:0][2:0][15:0] ccrVal,
    input wire logic [3:0]            ovfEvent,
    input wire logic [3:0][2:0]       chanEvent
);
    logic irBit;
    assign irBit = infraredDataValue ^ infraredPolaritySelect;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_reset_values: assert property (disable iff (1'b0)
        !nrst |=> count == '0 && ovfEvent == '0 && serialTransmitPin) else $error("bad reset state");
    a_write_lands: assert property (ccrWrEn && ccrWrChan != 2'h3 && !capMode[ccrWrTimer][ccrWrChan]
        && !(ccrWrTimer[1] && ccrWrChan == 2'h2)
        |=> ccrVal[$past(ccrWrTimer)][$past(ccrWrChan)] == $past(ccrWrData)) else $error("write lost");
    a_ovf_wraps: assert property ((ovfEvent[0] || ovfEvent[2])
        |-> (!ovfEvent[0] || count[0] == 16'h0) && (!ovfEvent[2] || count[2] == 16'h0)) else $error("no wrap");
    a_ovf_single: assert property (ovfEvent[1] |=> !ovfEvent[1]) else $error("long overflow pulse");
    a_stop_frozen: assert property (timerMode[1] == 2'h0 |=> $stable(count[1])) else $error("count moved");
    a_small_narrow: assert property (ccrVal[2][2] == 16'h0 && ccrVal[3][2] == 16'h0
        && !chanEvent[2][2] && !chanEvent[3][2]) else $error("small timer third channel");
    a_ir_bypass: assert property (!infraredEnable |=> serialTransmitPin == $past(serialTxData))
        else $error("bypass wrong");
    a_ir_ask: assert property ((infraredEnable && infraredModeSelect == QTIM_IR_ASK && !pwmPin[0][2]
        && !$past(pwmPin[0][2])) ##1 !pwmPin[0][2] |-> !serialTransmitPin) else $error("ask wrong");
    a_ir_fsk: assert property ((infraredEnable && infraredModeSelect == QTIM_IR_FSK && irBit
        && infraredDataSourceSelect == QTIM_IR_SRC_BIT && pwmPin[0][2] && $past(pwmPin[0][2]))
        ##1 pwmPin[0][2] |-> serialTransmitPin) else $error("fsk wrong");
    a_capture_count: assert property (chanEvent[0][1] && $past(capMode[0][1]) && $stable(count[0])
        |-> ccrVal[0][1] == count[0]) else $error("capture value");

    c_ovf: cover property (ovfEvent[0]);
    c_pair_capture: cover property (chanEvent[1][2]);
    c_ir_fsk: cover property (infraredEnable && infraredModeSelect);
endmodule : qtim_checker

bind qtim_top qtim_checker u_chk (.clk(clk), .nrst(nrst), .timerMode(timerMode), .ccrWrEn(ccrWrEn),
    .ccrWrTimer(ccrWrTimer), .ccrWrChan(ccrWrChan), .ccrWrData(ccrWrData), .capMode(capMode),
    .serialTxData(serialTxData), .infraredEnable(infraredEnable), .infraredPolaritySelect(infraredPolaritySelect),
    .infraredModeSelect(infraredModeSelect), .infraredDataSourceSelect(infraredDataSourceSelect),
    .infraredDataValue(infraredDataValue), .pwmPin(pwmPin), .serialTransmitPin(serialTransmitPin),
    .count(count), .ccrVal(ccrVal), .ovfEvent(ovfEvent), .chanEvent(chanEvent));

// ===== qtim_pin_model.sv
`timescale 1ns/1ps
module qtim_pin_model
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            nrst,
    // request to move the capture pins
    input  wire logic            flip,
    input  wire logic            serialTransmitPin,
    // far side pins
    output logic     [1:0][2:1]  capPin,
    output logic                 irLit
);
    // pins exist for channels 1 and 2 of the big timers only
    always_ff @(posedge clk) begin
        if (!nrst)
            capPin <= '0;
        else if (flip)
            capPin <= ~capPin;
    end
    // diode lights while the transmit pin is high
    assign irLit = serialTransmitPin;
endmodule : qtim_pin_model

// ===== quad_timer_ir_modulation_tb.sv
`timescale 1ns/1ps
module quad_timer_ir_modulation_tb;
    import qtim_pkg::*;
    logic                  clk, nrst, auxClk, subMainClk, ccrWrEn, flip, rtcOverflow, serialTxData;
    logic                  infrared_enable, irPol, irMode, irSrc, infrared_data_value, adcTrigger, serialTransmitPin, d, e;
    logic [3:0]            extClk, ovfEvent;
    logic [3:0][1:0]       clkSel, timerMode;
    logic [1:0]            ccrWrTimer, ccrWrChan;
    logic [15:0]           ccrWrData, n;
    logic [3:0][2:0]       capMode, outValue, chanEvent;
    logic [3:0][2:0][1:0]  capEdge, inSel, outMode;
    logic [1:0][2:1]       capPin, pwmPin;
    logic [3:0][15:0]      count;
    logic [3:0][2:0][15:0] ccrVal;
    logic [31:0]           seed = 32'h0000858c;
    logic [31:0]           r;
    logic [15:0]           expQ[$];
    int                    fails = 0;
    int                    n_compared = 0;
    int                    cyc = 0;
    int                    lastOvf = 0;
    int                    watchT = 0;

    qtim_top u_dut (.clk(clk), .nrst(nrst), .extClk(extClk), .auxClk(auxClk), .subMainClk(subMainClk),
        .clkSel(clkSel), .timerMode(timerMode), .ccrWrEn(ccrWrEn), .ccrWrTimer(ccrWrTimer),
        .ccrWrChan(ccrWrChan), .ccrWrData(ccrWrData), .capMode(capMode), .capEdge(capEdge), .inSel(inSel),
        .outMode(outMode), .outValue(outValue), .capPin(capPin), .rtcOverflow(rtcOverflow),
        .serialTxData(serialTxData), .infraredEnable(infrared_enable), .infraredPolaritySelect(irPol),
        .infraredModeSelect(irMode), .infraredDataSourceSelect(irSrc), .infraredDataValue(infrared_data_value),
        .pwmPin(pwmPin), .adcTrigger(adcTrigger), .serialTransmitPin(serialTransmitPin), .count(count),
        .ccrVal(ccrVal), .ovfEvent(ovfEvent), .chanEvent(chanEvent));
    qtim_pin_model u_pins (.clk(clk), .nrst(nrst), .flip(flip), .serialTransmitPin(serialTransmitPin),
        .capPin(capPin), .irLit());

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic wr(input int t, input int c, input logic [15:0] v);
        @(posedge clk);
        ccrWrEn    <= 1'b1;
        ccrWrTimer <= 2'(t);
        ccrWrChan  <= 2'(c);
        ccrWrData  <= v;
        @(posedge clk);
        ccrWrEn <= 1'b0;
    endtask : wr

    // wrap period in clk cycles; every source rises each second cycle
    task automatic period(input int t, input logic [1:0] m);
        logic [15:0] p;
        p = (m == 2'h1) ? 16'((n + 16'h1) * 2) : 16'(n * 4);
        @(posedge clk);
        timerMode <= '0;
        watchT    <= t;
        wr(t, 0, n);
        @(posedge clk);
        timerMode[t] <= m;
        chk("period value", n, ccrVal[t][0]);
        repeat (300) begin
            @(posedge clk);
            if (ovfEvent[t] === 1'b1) break;
        end
        @(posedge clk);
        repeat (3) expQ.push_back(p);
        repeat (1000) begin
            @(posedge clk);
            if (expQ.size() == 0) break;
        end
        chk("missing overflows", 16'h0, 16'(expQ.size()));
        expQ.delete();
    endtask : period

    task automatic capt(input int t, input int c, input logic [1:0] s, input logic ev);
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        capMode[t][c] <= 1'b1;
        capEdge[t][c] <= 2'h3;
        inSel[t][c]   <= s;
        repeat (3) @(posedge clk);
        flip           <= 1'b1;
        rtcOverflow    <= ~rtcOverflow;
        outValue[0][c] <= ~outValue[0][c];
        outValue[2][c] <= ~outValue[2][c];
        @(posedge clk);
        flip <= 1'b0;
        repeat (8) begin
            @(posedge clk);
            if (chanEvent[t][c] === 1'b1) seen = 1'b1;
        end
        chk("capture event", 16'(ev), 16'(seen));
        capMode[t][c] <= 1'b0;
    endtask : capt

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        auxClk     <= ~auxClk;
        subMainClk <= ~subMainClk;
        extClk     <= ~extClk;
    end

    // scoreboard: interval between overflows of the watched timer
    always @(posedge clk) begin
        cyc++;
        if (ovfEvent[watchT] === 1'b1) begin
            if (expQ.size() > 0) chk("overflow period", expQ.pop_front(), 16'(cyc - lastOvf));
            lastOvf = cyc;
        end
    end

    initial begin
        #100000;
        fails++;
        $display("watchdog expired");
        print_verdict();
    end

    initial begin
        {nrst, auxClk, subMainClk, flip, rtcOverflow, ccrWrEn, infrared_enable, irPol, irMode, irSrc, infrared_data_value} = '0;
        {timerMode, ccrWrTimer, ccrWrChan, ccrWrData, capMode, capEdge, inSel, outMode, outValue, extClk} = '0;
        serialTxData = 1'b1;
        clkSel = {2'h0, 2'h2, 2'h1, 2'h0};
        repeat (6) @(posedge clk);
        @(negedge clk);
        for (int t = 0; t < 4; t++) chk("count after reset", 16'h0, count[t]);
        chk("pin after reset", 16'h1, 16'(serialTransmitPin));
        @(posedge clk);
        nrst <= 1'b1;
        for (int t = 0; t < 4; t++) begin
            n = 16'(xs() % 32) + 16'h1;
            period(t, 2'h1);
            period(t, 2'h3);
        end
        $display("test periods done");
        for (int i = 0; i < 48; i++) begin
            r = xs();
            @(posedge clk);
            {infrared_enable, irPol, irMode, irSrc, infrared_data_value, serialTxData} <= r[5:0];
            outValue[0][2] <= r[6];
            outValue[1][2] <= r[7];
            outValue[1][1] <= r[8];
            repeat (3) @(posedge clk);
            @(negedge clk);
            d = (r[2] ? r[1] : r[0]) ^ r[4];
            e = !r[5] ? r[0] : (r[3] ? (d ? r[6] : r[7]) : (d & r[6]));
            chk("transmit pin", 16'(e), 16'(serialTransmitPin));
            chk("pwm pin", 16'(r[6]), 16'(pwmPin[0][2]));
            chk("pwm pin 1", 16'(r[7]), 16'(pwmPin[1][2]));
            chk("adc trigger", 16'(r[8]), 16'(adcTrigger));
        end
        $display("test infrared done");
        capt(0, 1, 2'h0, 1'b1);
        capt(0, 1, 2'h1, 1'b1);
        capt(0, 1, 2'h2, 1'b0);
        capt(0, 1, 2'h3, 1'b0);
        capt(1, 2, 2'h1, 1'b1);
        capt(3, 1, 2'h1, 1'b1);
        capt(0, 2, 2'h1, 1'b0);
        capt(1, 1, 2'h0, 1'b1);
        $display("test capture done");
        print_verdict();
    end
endmodule : quad_timer_ir_modulation_tb
